// *** verilog/asmfd_defs.svh ***
// offsets, field positions and reset values of the monitor block
`ifndef ASMFD_DEFS_SVH
`define ASMFD_DEFS_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ASMFD_SYNC_CTRL 9'h100
`define ASMFD_FD_CTRL 9'h104
`define ASMFD_COARSE 9'h105
`define ASMFD_FUT_LO 9'h106
`define ASMFD_FUT_HI 9'h107
`define ASMFD_FLT_LO 9'h108
`define ASMFD_FLT_HI 9'h109
`define ASMFD_DWELL_LO 9'h10A
`define ASMFD_DWELL_HI 9'h10B
`define ASMFD_DCC 9'h10C
`define ASMFD_DCA_LO 9'h10D
`define ASMFD_DCA_HI 9'h10E
`define ASMFD_DCB_LO 9'h10F
`define ASMFD_DCB_HI 9'h110
`define ASMFD_SPC 9'h111
`define ASMFD_SMC 9'h112
`define ASMFD_PER_0 9'h113
`define ASMFD_PER_1 9'h114
`define ASMFD_PER_2 9'h115
`define ASMFD_RES_0 9'h116
`define ASMFD_RES_1 9'h117
`define ASMFD_RES_2 9'h118
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ASMFD_SYNC_MASTER 0
`define ASMFD_SYNC_DIV 1
`define ASMFD_SYNC_ONCE 2
`define ASMFD_SYNC_MON 7
`define ASMFD_DCC_MON 0
`define ASMFD_DCC_PATH 1
`define ASMFD_DCC_FREEZE 6
`define ASMFD_SPC_EN 0
`define ASMFD_SPC_SLEEP 1
`define ASMFD_SPC_THR 4
`define ASMFD_SPC_PEAK 5
`define ASMFD_SPC_RMS 6
`define ASMFD_SMC_EN 0
`define ASMFD_SMC_MS 3
`define ASMFD_SMC_CPLX 7
// ----------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------
`define ASMFD_SPC_RST 8'h04
`define ASMFD_PER_RST 24'h000040
`define ASMFD_K_MAX 4'hD
`define ASMFD_K_BASE 5'h0E
`endif

// *** verilog/asmfd_pkg.sv ***
// types shared by the monitor and fast-detect block
package asmfd_pkg;
    typedef enum logic [0:0] {SH_IDLE, SH_SHIFT} asmfd_ser_e;
    typedef logic [19:0] asmfd_res_t;
endpackage : asmfd_pkg

// *** verilog/asmfd_top.sv ***
// signal monitor, fast detect, dc correction and monitor serial port logic
`timescale 1ns/1ps
`include "asmfd_defs.svh"

// ----------------------------------------------------------------
// fifo
// ----------------------------------------------------------------
module asmfd_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
        $error("fifo depth must be a power of two");
    end

    assign in_ready = (cnt != (AW+1)'(DEPTH));
    assign out_valid = (cnt != '0);
    assign out_data = mem[rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else begin
            if (push) wp <= wp + 1'b1;
            if (pop) rp <= rp + 1'b1;
            if (push && !pop) cnt <= cnt + 1'b1;
            else if (pop && !push) cnt <= cnt - 1'b1;
        end
    end
endmodule : asmfd_fifo

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module asmfd_top #(
    parameter int FIFO_DEPTH = 8
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // register port from the serial control port
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [8:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    // converter data and channel state
    input wire logic signed [9:0] ADC_A,
    input wire logic signed [9:0] ADC_B,
    input wire logic CH_A_ACTIVE,
    input wire logic CH_B_ACTIVE,
    input wire logic LVDS_INTERLEAVE,
    // sync pin and gated syncs
    input wire logic SYNC_IN,
    output logic DIV_SYNC,
    output logic MON_SYNC,
    // fast detect pins {b ig,fl,fu, a ig,fl,fu}
    output logic [5:0] FD_OUT,
    output logic FD_OE,
    // corrected data path
    output logic signed [10:0] CORR_A,
    output logic signed [10:0] CORR_B,
    // monitor serial port
    output logic MON_SCLK,
    output logic MON_SDO,
    output logic MON_FRAME
);
    localparam int FW = 21;

    if (FIFO_DEPTH < 4) begin : g_chk
        $error("fifo must hold the three words of one period");
    end

    logic [7:0] sc;
    logic [3:0] fdc;
    logic [2:0] coarse;
    logic [12:0] fut;
    logic [12:0] flt;
    logic [15:0] dwell;
    logic [6:0] dcc;
    logic [6:0] spc;
    logic [7:0] smc;
    logic [23:0] period;
    asmfd_pkg::asmfd_res_t result;
    logic [7:0] rd_mux;
    logic sync_m, sync_s, sync_d, sync_ev, div_once, mon_sync_ev;
    logic signed [9:0] adc [2];
    logic [9:0] mag [2];
    logic signed [39:0] acc [2];
    logic signed [13:0] dc14 [2];
    logic signed [9:0] dc10 [2];
    logic signed [10:0] s [2];
    logic signed [21:0] sq [2];
    logic [4:0] dc_sh;
    logic [15:0] dw [2];
    logic fu [2];
    logic fl [2];
    logic ig [2];
    logic fd_sel;
    logic [23:0] pcnt;
    logic [45:0] psum, sum_t;
    logic [9:0] pk, pk_t, tc, tc_t, amag;
    logic [21:0] p;
    logic [22:0] mean;
    logic [19:0] ms20, rms20, word_ms, word_mg;
    logic per_end;
    logic [2:0] pend;
    logic [9:0] word_pk, word_th;
    logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [FW-1:0] f_in_data, f_out_data;
    asmfd_pkg::asmfd_ser_e sh_state;
    logic [19:0] shreg;
    logic [4:0] bits;
    logic [1:0] dcnt, half;
    logic tick;

    function automatic logic [4:0] flog2(input logic [23:0] v);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 24; i++) begin
            if (v[i]) r = 5'(i);
        end
        return r;
    endfunction : flog2

    function automatic logic [11:0] isqrt(input logic [22:0] v);
        logic [11:0] r;
        logic [11:0] t;
        r = 12'h000;
        for (int i = 11; i >= 0; i--) begin
            t = r | (12'h001 << i);
            if (24'(t) * 24'(t) <= 24'(v)) r = t;
        end
        return r;
    endfunction : isqrt

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sc <= 8'h00;
            fdc <= 4'h0;
            coarse <= 3'h0;
            fut <= 13'h0000;
            flt <= 13'h0000;
            dwell <= 16'h0000;
            dcc <= 7'h00;
            spc <= 7'(`ASMFD_SPC_RST);
            smc <= 8'h00;
            period <= `ASMFD_PER_RST;
        end else begin
            if (div_once) sc[`ASMFD_SYNC_DIV] <= 1'b0;
            if (REG_WR) begin
                if (REG_ADDR == `ASMFD_SYNC_CTRL) sc <= {REG_WDATA[7], 4'h0, REG_WDATA[2:0]};
                else if (REG_ADDR == `ASMFD_FD_CTRL) fdc <= REG_WDATA[3:0];
                else if (REG_ADDR == `ASMFD_COARSE) coarse <= REG_WDATA[2:0];
                else if (REG_ADDR == `ASMFD_FUT_LO) fut[7:0] <= REG_WDATA;
                else if (REG_ADDR == `ASMFD_FUT_HI) fut[12:8] <= REG_WDATA[4:0];
                else if (REG_ADDR == `ASMFD_FLT_LO) flt[7:0] <= REG_WDATA;
                else if (REG_ADDR == `ASMFD_FLT_HI) flt[12:8] <= REG_WDATA[4:0];
                else if (REG_ADDR == `ASMFD_DWELL_LO) dwell[7:0] <= REG_WDATA;
                else if (REG_ADDR == `ASMFD_DWELL_HI) dwell[15:8] <= REG_WDATA;
                else if (REG_ADDR == `ASMFD_DCC) dcc <= REG_WDATA[6:0];
                else if (REG_ADDR == `ASMFD_SPC) spc <= REG_WDATA[6:0];
                else if (REG_ADDR == `ASMFD_SMC) smc <= {REG_WDATA[7], 3'h0, REG_WDATA[3:0]};
                else if (REG_ADDR == `ASMFD_PER_0) period[7:0] <= REG_WDATA;
                else if (REG_ADDR == `ASMFD_PER_1) period[15:8] <= REG_WDATA;
                else if (REG_ADDR == `ASMFD_PER_2) period[23:16] <= REG_WDATA;
            end
        end
    end

    always_comb begin
        if (REG_ADDR == `ASMFD_SYNC_CTRL) rd_mux = sc;
        else if (REG_ADDR == `ASMFD_FD_CTRL) rd_mux = {4'h0, fdc};
        else if (REG_ADDR == `ASMFD_COARSE) rd_mux = {5'h00, coarse};
        else if (REG_ADDR == `ASMFD_FUT_LO) rd_mux = fut[7:0];
        else if (REG_ADDR == `ASMFD_FUT_HI) rd_mux = {3'h0, fut[12:8]};
        else if (REG_ADDR == `ASMFD_FLT_LO) rd_mux = flt[7:0];
        else if (REG_ADDR == `ASMFD_FLT_HI) rd_mux = {3'h0, flt[12:8]};
        else if (REG_ADDR == `ASMFD_DWELL_LO) rd_mux = dwell[7:0];
        else if (REG_ADDR == `ASMFD_DWELL_HI) rd_mux = dwell[15:8];
        else if (REG_ADDR == `ASMFD_DCC) rd_mux = {1'b0, dcc};
        else if (REG_ADDR == `ASMFD_DCA_LO) rd_mux = dc14[0][7:0];
        else if (REG_ADDR == `ASMFD_DCA_HI) rd_mux = {2'h0, dc14[0][13:8]};
        else if (REG_ADDR == `ASMFD_DCB_LO) rd_mux = dc14[1][7:0];
        else if (REG_ADDR == `ASMFD_DCB_HI) rd_mux = {2'h0, dc14[1][13:8]};
        else if (REG_ADDR == `ASMFD_SPC) rd_mux = {1'b0, spc};
        else if (REG_ADDR == `ASMFD_SMC) rd_mux = smc;
        else if (REG_ADDR == `ASMFD_PER_0) rd_mux = period[7:0];
        else if (REG_ADDR == `ASMFD_PER_1) rd_mux = period[15:8];
        else if (REG_ADDR == `ASMFD_PER_2) rd_mux = period[23:16];
        else if (REG_ADDR == `ASMFD_RES_0) rd_mux = result[7:0];
        else if (REG_ADDR == `ASMFD_RES_1) rd_mux = result[15:8];
        else if (REG_ADDR == `ASMFD_RES_2) rd_mux = {4'h0, result[19:16]};
        else rd_mux = 8'h00;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) REG_RDATA <= 8'h00;
        else if (REG_RD) REG_RDATA <= rd_mux;
    end

    // ----------------------------------------------------------------
    // sync gating
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            sync_m <= 1'b0;
            sync_s <= 1'b0;
            sync_d <= 1'b0;
        end else begin
            sync_m <= SYNC_IN;
            sync_s <= sync_m;
            sync_d <= sync_s;
        end
    end

    // one event per pin edge, however long the pin stays high
    assign sync_ev = sync_s && !sync_d;
    assign mon_sync_ev = sync_ev && sc[`ASMFD_SYNC_MASTER] && sc[`ASMFD_SYNC_MON];
    assign div_once = sync_ev && sc[`ASMFD_SYNC_MASTER] && sc[`ASMFD_SYNC_DIV]
        && sc[`ASMFD_SYNC_ONCE];

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            DIV_SYNC <= 1'b0;
            MON_SYNC <= 1'b0;
        end else begin
            DIV_SYNC <= sync_ev && sc[`ASMFD_SYNC_MASTER] && sc[`ASMFD_SYNC_DIV];
            MON_SYNC <= mon_sync_ev;
        end
    end

    // ----------------------------------------------------------------
    // magnitude, dc estimate and corrected samples
    // ----------------------------------------------------------------
    assign adc[0] = ADC_A;
    assign adc[1] = ADC_B;
    assign dc_sh = `ASMFD_K_BASE + 5'((dcc[5:2] > `ASMFD_K_MAX) ? `ASMFD_K_MAX : dcc[5:2]);

    always_comb begin
        for (int c = 0; c < 2; c++) begin
            mag[c] = adc[c][9] ? 10'(-adc[c]) : 10'(adc[c]);
            dc14[c] = 14'(acc[c] >>> (dc_sh - 5'h04));
            dc10[c] = 10'(dc14[c] >>> 4);
            s[c] = dcc[`ASMFD_DCC_MON] ? 11'(adc[c]) - 11'(dc10[c]) : 11'(adc[c]);
            sq[c] = s[c] * s[c];
        end
    end

    // first-order averager: the estimate carries 4 fraction bits below the lsb
    always_ff @(posedge CLK_SYS) begin
        for (int c = 0; c < 2; c++) begin
            if (SRST) acc[c] <= 40'h0000000000;
            else if (!dcc[`ASMFD_DCC_FREEZE])
                acc[c] <= acc[c] + 40'(adc[c]) - (acc[c] >>> dc_sh);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            CORR_A <= 11'h000;
            CORR_B <= 11'h000;
        end else begin
            CORR_A <= dcc[`ASMFD_DCC_PATH] ? 11'(ADC_A) - 11'(dc10[0]) : 11'(ADC_A);
            CORR_B <= dcc[`ASMFD_DCC_PATH] ? 11'(ADC_B) - 11'(dc10[1]) : 11'(ADC_B);
        end
    end

    // ----------------------------------------------------------------
    // fast detect
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        for (int c = 0; c < 2; c++) begin
            if (SRST) begin
                dw[c] <= 16'h0000;
                fu[c] <= 1'b0;
                fl[c] <= 1'b0;
                ig[c] <= 1'b0;
            end else begin
                fu[c] <= 13'(mag[c]) > fut;
                fl[c] <= 13'(mag[c]) < flt;
                if (13'(mag[c]) >= flt) dw[c] <= 16'h0000;
                else if (dw[c] != 16'hFFFF) dw[c] <= dw[c] + 16'h0001;
                ig[c] <= (13'(mag[c]) < flt) && (dw[c] >= dwell);
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            fd_sel <= 1'b0;
            FD_OUT <= 6'h00;
            FD_OE <= 1'b0;
        end else begin
            fd_sel <= !fd_sel;
            if (LVDS_INTERLEAVE) begin
                // one live channel is repeated rather than interleaved with idle data
                if (CH_A_ACTIVE && (!CH_B_ACTIVE || !fd_sel))
                    FD_OUT <= {2{ig[0], fl[0], fu[0]}};
                else
                    FD_OUT <= {2{ig[1], fl[1], fu[1]}};
                FD_OE <= fdc[0] && (CH_A_ACTIVE || CH_B_ACTIVE);
            end else begin
                FD_OUT <= {ig[1], fl[1], fu[1], ig[0], fl[0], fu[0]};
                FD_OE <= fdc[0];
            end
        end
    end

    // ----------------------------------------------------------------
    // signal monitor
    // ----------------------------------------------------------------
    assign p = smc[`ASMFD_SMC_CPLX] ? 22'(sq[0]) + 22'(sq[1]) : 22'(sq[0]);
    assign amag = s[0][10] ? 10'(-s[0]) : 10'(s[0]);
    assign sum_t = psum + 46'(p);
    assign pk_t = (amag > pk) ? amag : pk;
    assign tc_t = ((13'(mag[0]) > fut) && (tc != 10'h3FF)) ? tc + 10'h001 : tc;
    // power-of-two divisor: exact only for power-of-two periods
    assign mean = 23'(sum_t >> flog2(period));
    assign ms20 = (mean > 23'h0FFFFF) ? 20'hFFFFF : mean[19:0];
    assign rms20 = 20'(isqrt(mean));
    assign word_ms = smc[`ASMFD_SMC_MS] ? ms20 : rms20;
    assign per_end = smc[`ASMFD_SMC_EN] && !mon_sync_ev
        && (25'(pcnt) + 25'h0000001 >= 25'(period));

    always_ff @(posedge CLK_SYS) begin
        if (SRST || !smc[`ASMFD_SMC_EN] || mon_sync_ev || per_end) begin
            pcnt <= 24'h000000;
            psum <= 46'h0;
            pk <= 10'h000;
            tc <= 10'h000;
        end else begin
            pcnt <= pcnt + 24'h000001;
            psum <= sum_t;
            pk <= pk_t;
            tc <= tc_t;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SRST) result <= 20'h00000;
        else if (per_end) begin
            if (smc[2:1] == 2'h0) result <= word_ms;
            else if (smc[2:1] == 2'h1) result <= 20'(pk_t);
            else result <= 20'(tc_t);
        end
    end

    // ----------------------------------------------------------------
    // monitor serial port
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            pend <= 3'h0;
            word_pk <= 10'h000;
            word_th <= 10'h000;
            word_mg <= 20'h00000;
        end else if (per_end && spc[`ASMFD_SPC_EN]) begin
            pend <= {spc[`ASMFD_SPC_RMS], spc[`ASMFD_SPC_PEAK], spc[`ASMFD_SPC_THR]};
            word_pk <= pk_t;
            word_th <= tc_t;
            word_mg <= word_ms;
        end else if (f_in_valid && f_in_ready) begin
            // words leave in order magnitude, peak, crossing; a stalled fifo holds them back
            if (pend[2]) pend[2] <= 1'b0;
            else if (pend[1]) pend[1] <= 1'b0;
            else pend[0] <= 1'b0;
        end
    end

    assign f_in_valid = (pend != 3'h0);
    assign f_in_data = pend[2] ? {1'b1, word_mg} : {1'b0, (pend[1] ? word_pk : word_th), 10'h000};

    asmfd_fifo #(.WIDTH(FW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(CLK_SYS),
        .srst(SRST),
        .in_valid(f_in_valid),
        .in_ready(f_in_ready),
        .in_data(f_in_data),
        .out_valid(f_out_valid),
        .out_ready(f_out_ready),
        .out_data(f_out_data)
    );

    assign half = (spc[3:2] == 2'h3) ? 2'h3 : (spc[3:2] == 2'h2) ? 2'h1 : 2'h0;
    assign tick = (dcnt == half);
    assign f_out_ready = tick && MON_SCLK && (bits <= 5'h01);

    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            dcnt <= 2'h0;
            MON_SCLK <= 1'b0;
            MON_SDO <= 1'b0;
            MON_FRAME <= 1'b0;
            shreg <= 20'h00000;
            bits <= 5'h00;
            sh_state <= asmfd_pkg::SH_IDLE;
        end else begin
            dcnt <= tick ? 2'h0 : dcnt + 2'h1;
            if (tick) begin
                if (sh_state == asmfd_pkg::SH_IDLE && !f_out_valid && !MON_SCLK
                    && spc[`ASMFD_SPC_SLEEP])
                    MON_SCLK <= 1'b0;
                else
                    MON_SCLK <= !MON_SCLK;
                if (MON_SCLK) begin
                    // data changes on the falling edge, receiver samples on the rising one
                    MON_FRAME <= 1'b0;
                    if (bits > 5'h01) begin
                        shreg <= {shreg[18:0], 1'b0};
                        MON_SDO <= shreg[18];
                        bits <= bits - 5'h01;
                    end else if (f_out_valid) begin
                        shreg <= f_out_data[19:0];
                        MON_SDO <= f_out_data[19];
                        MON_FRAME <= 1'b1;
                        bits <= f_out_data[20] ? 5'h14 : 5'h0A;
                        sh_state <= asmfd_pkg::SH_SHIFT;
                    end else begin
                        bits <= 5'h00;
                        MON_SDO <= 1'b0;
                        sh_state <= asmfd_pkg::SH_IDLE;
                    end
                end
            end
        end
    end
endmodule : asmfd_top

// *** verif/asmfd_checker.sv ***
// port assertions of the monitor and fast-detect block
`timescale 1ns/1ps
module asmfd_checker (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic SRST,
    // register read port
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    // sync
    input wire logic SYNC_IN,
    input wire logic DIV_SYNC,
    input wire logic MON_SYNC,
    // fast detect
    input wire logic CH_A_ACTIVE,
    input wire logic CH_B_ACTIVE,
    input wire logic LVDS_INTERLEAVE,
    input wire logic [5:0] FD_OUT,
    input wire logic FD_OE,
    // monitor serial port
    input wire logic MON_SCLK,
    input wire logic MON_SDO,
    input wire logic MON_FRAME
);
    default clocking @(posedge CLK_SYS);
    endclocking
    default disable iff (SRST);
    div_pulse_one_a: assert property (DIV_SYNC |=> !DIV_SYNC)
        else $error("divider sync wider than one cycle");
    mon_pulse_one_a: assert property (MON_SYNC |=> !MON_SYNC)
        else $error("monitor sync wider than one cycle");
    div_sync_cause_a: assert property (DIV_SYNC |-> $past(SYNC_IN, 3))
        else $error("divider sync without pin");
    mon_sync_cause_a: assert property (MON_SYNC |-> $past(SYNC_IN, 3))
        else $error("monitor sync without pin");
    fd_float_a: assert property ((LVDS_INTERLEAVE && !CH_A_ACTIVE && !CH_B_ACTIVE)[*4]
        |-> !FD_OE) else $error("fast detect driven with both channels off");
    fd_repeat_a: assert property (LVDS_INTERLEAVE[*4] |-> FD_OUT[5:3] == FD_OUT[2:0])
        else $error("interleaved halves differ");
    gain_needs_low_a: assert property (FD_OUT[2] |-> FD_OUT[1])
        else $error("increase gain without lower flag");
    sdo_on_fall_a: assert property ($changed(MON_SDO) |-> $fell(MON_SCLK))
        else $error("serial data moved off the falling clock");
    frame_on_fall_a: assert property ($rose(MON_FRAME) |-> $fell(MON_SCLK))
        else $error("frame started off the falling clock");
    rdata_hold_a: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    cover property (DIV_SYNC);
    cover property (MON_SYNC);
    cover property ($rose(MON_FRAME));
endmodule : asmfd_checker
bind asmfd_top asmfd_checker asmfd_checker_i (.CLK_SYS, .SRST, .REG_RD, .REG_RDATA, .SYNC_IN,
    .DIV_SYNC, .MON_SYNC, .CH_A_ACTIVE, .CH_B_ACTIVE, .LVDS_INTERLEAVE, .FD_OUT, .FD_OE,
    .MON_SCLK, .MON_SDO, .MON_FRAME);

// *** verif/asmfd_rx.sv ***
// downstream receiver of monitor serial words
`timescale 1ns/1ps
module asmfd_rx (
    // serial inputs
    input wire logic sclk,
    input wire logic sdo,
    input wire logic frame,
    // last whole word and word count
    output logic [19:0] word,
    output int count
);
    logic [19:0] sh;
    int n;
    // data moves on the fall, so it is taken on the rise
    always_ff @(posedge sclk) begin
        sh <= frame ? {19'h00000, sdo} : {sh[18:0], sdo};
        n <= frame ? 1 : n + 1;
        if (!frame && n == 19) begin
            word <= {sh[18:0], sdo};
            count <= count + 1;
        end
    end
endmodule : asmfd_rx

// *** verif/adc_signal_monitor_fast_detect_test.sv ***
// self-checking bench of the monitor and fast-detect block
`timescale 1ns/1ps
`include "asmfd_defs.svh"
module adc_signal_monitor_fast_detect_test;
    logic CLK_SYS = 1'b0, SRST = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0, SYNC_IN = 1'b0;
    logic CH_A_ACTIVE = 1'b1, CH_B_ACTIVE = 1'b1, LVDS_INTERLEAVE = 1'b0;
    logic [8:0] REG_ADDR = 9'h000;
    logic [7:0] REG_WDATA = 8'h00, REG_RDATA, rd_v;
    logic signed [9:0] ADC_A = 10'h000, ADC_B = 10'h000;
    logic DIV_SYNC, MON_SYNC, FD_OE, MON_SCLK, MON_SDO, MON_FRAME;
    logic [5:0] FD_OUT;
    logic signed [10:0] CORR_A, CORR_B;
    logic [19:0] rx_word;
    logic [31:0] seed = 32'h434F9D44;
    int fails = 0, check_count = 0, rx_count, d, m;
    logic [8:0] ra [7] = '{`ASMFD_SPC, `ASMFD_PER_0, `ASMFD_SMC, 9'h119, `ASMFD_DCA_LO,
        `ASMFD_FUT_HI, `ASMFD_DWELL_HI};
    logic [7:0] re [7] = '{8'h04, 8'h40, 8'h00, 8'h00, 8'h00, 8'h1F, 8'hA5};
    logic [7:0] sc [5] = '{8'h03, 8'h02, 8'h07, 8'hFF, 8'h81};
    logic [7:0] rb [5] = '{8'h03, 8'h02, 8'h05, 8'h05, 8'h81};
    logic [7:0] mc [6] = '{8'h01, 8'h09, 8'h03, 8'h05, 8'h07, 8'h89};
    logic [19:0] me [6] = '{20'h0012C, 20'h15F90, 20'h0012C, 20'h00080, 20'h00080, 20'h1FBD0};
    logic [2:0] oc [4] = '{3'b011, 3'b100, 3'b101, 3'b011};
    initial begin
        forever #50 CLK_SYS = ~CLK_SYS;
    end
    asmfd_top asmfd_top_i (.CLK_SYS, .SRST, .REG_WR, .REG_RD, .REG_ADDR, .REG_WDATA, .REG_RDATA,
        .ADC_A, .ADC_B, .CH_A_ACTIVE, .CH_B_ACTIVE, .LVDS_INTERLEAVE, .SYNC_IN, .DIV_SYNC,
        .MON_SYNC, .FD_OUT, .FD_OE, .CORR_A, .CORR_B, .MON_SCLK, .MON_SDO, .MON_FRAME);
    asmfd_rx asmfd_rx_i (.sclk(MON_SCLK), .sdo(MON_SDO), .frame(MON_FRAME), .word(rx_word),
        .count(rx_count));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int mag(input logic signed [9:0] x);
        return x < 0 ? -int'(x) : int'(x);
    endfunction : mag
    task chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [8:0] a, input logic [7:0] v);
        @(negedge CLK_SYS);
        REG_WR = 1'b1;
        REG_ADDR = a;
        REG_WDATA = v;
        @(negedge CLK_SYS);
        REG_WR = 1'b0;
    endtask : wr
    task rd(input logic [8:0] a);
        @(negedge CLK_SYS);
        REG_RD = 1'b1;
        REG_ADDR = a;
        @(negedge CLK_SYS);
        REG_RD = 1'b0;
        @(negedge CLK_SYS);
        rd_v = REG_RDATA;
    endtask : rd
    task print_verdict;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (6) @(negedge CLK_SYS);
        SRST = 1'b0;
        // freeze keeps the dc value at zero for the whole run
        wr(`ASMFD_DCC, 8'h40);
        wr(`ASMFD_FUT_HI, 8'hFF);
        wr(`ASMFD_DWELL_HI, 8'hA5);
        wr(`ASMFD_DCA_LO, 8'hFF);
        wr(9'h119, 8'hFF);
        for (int i = 0; i < 7; i++) begin
            rd(ra[i]);
            chk(rd_v, re[i]);
        end
        for (int i = 0; i < 5; i++) begin
            if (sc[i] != 8'hFF) wr(`ASMFD_SYNC_CTRL, sc[i]);
            d = 0;
            m = 0;
            SYNC_IN = 1'b1;
            for (int k = 0; k < 8; k++) begin
                @(negedge CLK_SYS);
                d += (DIV_SYNC === 1'b1);
                m += (MON_SYNC === 1'b1);
            end
            SYNC_IN = 1'b0;
            rd(`ASMFD_SYNC_CTRL);
            chk(d, 5'b00101 >> i & 1);
            chk(m, 5'b10000 >> i & 1);
            chk(rd_v, rb[i]);
        end
        wr(`ASMFD_FD_CTRL, 8'h01);
        for (int i = 0; i < 20; i++) begin
            seed = lfsr(seed);
            wr(`ASMFD_FUT_LO, seed[7:0]);
            wr(`ASMFD_FUT_HI, {6'h00, seed[9:8]});
            wr(`ASMFD_FLT_LO, seed[17:10]);
            wr(`ASMFD_FLT_HI, {6'h00, seed[19:18]});
            ADC_A = (i == 0) ? -10'sd512 : seed[29:20];
            repeat (4) @(negedge CLK_SYS);
            chk(FD_OUT[1:0], {mag(ADC_A) < seed[19:10], mag(ADC_A) > seed[9:0]});
        end
        for (int i = 0; i < 4; i++) begin
            wr(`ASMFD_FD_CTRL, {7'h00, i != 0});
            {LVDS_INTERLEAVE, CH_A_ACTIVE, CH_B_ACTIVE} = oc[i];
            repeat (4) @(negedge CLK_SYS);
            chk(FD_OE, 4'b1100 >> i & 1);
            if (i == 2) chk(FD_OUT[5:3], FD_OUT[2:0]);
        end
        wr(`ASMFD_DWELL_LO, 8'h05);
        wr(`ASMFD_DWELL_HI, 8'h00);
        wr(`ASMFD_FLT_LO, 8'h00);
        wr(`ASMFD_FLT_HI, 8'h01);
        ADC_A = 10'sd500;
        repeat (4) @(negedge CLK_SYS);
        ADC_A = 10'sd10;
        repeat (3) @(negedge CLK_SYS);
        chk(FD_OUT[2], 1'b0);
        repeat (10) @(negedge CLK_SYS);
        chk(FD_OUT[2], 1'b1);
        wr(`ASMFD_DCC, 8'h42);
        ADC_A = -10'sd300;
        ADC_B = 10'sd200;
        repeat (3) @(negedge CLK_SYS);
        chk(24'(CORR_A), -24'sd300);
        chk(24'(CORR_B), 24'd200);
        // periods that are not a power of two are inaccurate
        wr(`ASMFD_PER_0, 8'h80);
        wr(`ASMFD_FUT_LO, 8'h64);
        wr(`ASMFD_FUT_HI, 8'h00);
        wr(`ASMFD_SPC, 8'h45);
        for (int i = 0; i < 6; i++) begin
            wr(`ASMFD_SMC, mc[i]);
            repeat (300) @(negedge CLK_SYS);
            for (int b = 0; b < 3; b++) begin
                rd(9'(`ASMFD_RES_0 + b));
                chk(rd_v, 8'(me[i] >> 8 * b));
            end
        end
        wr(`ASMFD_SMC, 8'h09);
        // no sleep: the clock runs free for the edge count
        for (int j = 0; j < 3; j++) begin
            wr(`ASMFD_SPC, {4'h4, 2'(j + 1), 2'b01});
            repeat (16) @(negedge CLK_SYS);
            d = 0;
            for (int k = 0; k < 64; k++) begin
                m = (MON_SCLK === 1'b1);
                @(negedge CLK_SYS);
                d += (MON_SCLK === 1'b1 && m == 0);
            end
            chk(d, 32 >> j);
        end
        wr(`ASMFD_SPC, 8'h47);
        d = rx_count + 3;
        for (int k = 0; k < 3000 && rx_count < d; k++) @(negedge CLK_SYS);
        if (rx_count < d) fails++;
        chk(rx_word, 20'h15F90);
        wr(`ASMFD_SMC, 8'h00);
        repeat (600) @(negedge CLK_SYS);
        d = 0;
        for (int k = 0; k < 32; k++) begin
            @(negedge CLK_SYS);
            d += (MON_SCLK !== 1'b0);
        end
        chk(d, 0);
        rd(`ASMFD_DCA_HI);
        chk(rd_v, 8'h00);
        print_verdict();
    end
endmodule : adc_signal_monitor_fast_detect_test
